/* File: hw/hrjs_pkg.sv */
package hrjs_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int KEYGEN_HOLD_S = 30;
	localparam int KEYGEN_HOLD_CYC = KEYGEN_HOLD_S * CLK_HZ;
	localparam int SHORT_MAX_S = 2;
	localparam int SHORT_MAX_CYC = SHORT_MAX_S * CLK_HZ;
	localparam int JOIN_WAIT_S = 30;
	localparam int JOIN_WAIT_CYC = JOIN_WAIT_S * CLK_HZ;
	localparam int CNT_W = 29;
	localparam int BLINK_W = 23;
	localparam int FIFO_AW = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] OFS_DEFER = 8'h00;
	localparam logic [7:0] OFS_PACKET_OPTIONS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_OWN = 8'h0C;
	localparam logic [7:0] OFS_TARGET = 8'h10;
	localparam logic [7:0] OFS_SCHEME = 8'h14;
	localparam logic [7:0] OFS_SECURITY_OPTIONS = 8'h18;
	localparam logic [7:0] OFS_KEY0 = 8'h1C;
	localparam logic [7:0] OFS_KEY3 = 8'h28;
	localparam logic [7:0] OFS_CTRL = 8'h2C;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] DEFER_ON = 8'h01;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] MASK_DEFAULT = 32'hFFFFFFFF;
	localparam logic [31:0] MASK_KEYGEN = 32'h000000FF;
	localparam logic [31:0] ADDR_RESET = 32'hFFFFFFFF;
	localparam logic [7:0] SCHEME_EXT_ENC = 8'h27;
	localparam logic [7:0] SCHEME_EXT_PLAIN = 8'h07;
	localparam int PK_RX_PACKET_MODE_BIT = 0;
	localparam int SEC_KEYGEN_ENC = 0;
	localparam int SEC_NO_ADDR = 1;
	localparam int SEC_NO_KEY = 2;
	localparam int SEC_NO_SHARE = 3;
	localparam int CTL_KEY_SET = 0;
	localparam int CTL_KEY_CLR = 1;
	localparam int CTL_JOIN = 2;
	localparam int CTL_CANCEL = 3;
	localparam int CTL_KEYGEN = 4;
	localparam int CTL_ENC_ON = 5;
	localparam int CTL_ENC_OFF = 6;
	localparam int BLINK_PH_HI = 22;
	localparam int BLINK_PH_LO = 20;
	localparam logic [2:0] BLINK_ON_A = 3'h0;
	localparam logic [2:0] BLINK_ON_B = 3'h2;
	// arbitrary neutral values
	localparam logic [127:0] FACTORY_KEY = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
	localparam logic [127:0] LFSR_SEED = 128'h00000000000000000000000000000001;
	typedef enum logic [1:0] {PB_IDLE, PB_HELD, PB_LONG} hrjs_pb_t;
	typedef enum logic {JN_IDLE, JN_SEARCH} hrjs_join_t;
endpackage : hrjs_pkg

/* File: hw/hrjs_top.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module hrjs_top import hrjs_pkg::*; #(
	parameter int HOLD_CYC = KEYGEN_HOLD_CYC,
	parameter int SHORT_CYC = SHORT_MAX_CYC,
	parameter int JOIN_CYC = JOIN_WAIT_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cmd_sel_n,
	input wire logic host_rx_valid,
	input wire logic [7:0] host_rx_data,
	output logic rf_tx_valid_r,
	output logic [7:0] rf_tx_data_r,
	output logic rf_tx_encrypt_r,
	output logic cmd_valid_r,
	output logic [7:0] cmd_data_r,
	input wire logic rf_rx_valid,
	input wire logic [7:0] rf_rx_data,
	input wire logic rf_rx_key_ok,
	output logic uart_out_valid_r,
	output logic [7:0] uart_out_data_r,
	input wire logic uart_out_ready,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_r,
	input wire logic push_button_line,
	output logic status_led_line_r,
	input wire logic rf_noise_bit,
	output logic [127:0] cipher_key_r,
	output logic [127:0] net_key_r,
	output logic join_search_r,
	output logic join_as_admin_r,
	output logic [31:0] join_offer_addr_r,
	input wire logic join_peer_done,
	input wire logic join_rx_valid,
	input wire logic [127:0] join_rx_key,
	input wire logic [31:0] join_rx_mask,
	input wire logic [31:0] join_rx_addr,
	input wire logic [31:0] join_admin_addr,
	output logic nv_save_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// routing group
	logic rf_tx_valid_nxt, cmd_valid_nxt, uart_out_valid_nxt;
	logic [7:0] uart_out_data_nxt;
	logic [FIFO_AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [7:0] mem [FIFO_DEPTH];
	logic fifo_full, fifo_empty, release_ok, push, pop;
	// config group
	logic [7:0] defer_r, defer_nxt, packet_options_r, packet_options_nxt, scheme_r, scheme_nxt, security_options_r, security_options_nxt;
	logic [31:0] mask_r, mask_nxt, own_r, own_nxt, target_r, target_nxt, rdata_nxt;
	logic [127:0] key_r, key_nxt, lfsr_r, lfsr_nxt, cipher_key_nxt;
	logic key_valid_r, key_valid_nxt, enc_en_r, enc_en_nxt, is_admin_r, is_admin_nxt;
	logic nv_save_nxt, led_nxt, offer_en_nxt;
	logic [15:0] node_cnt_r, node_cnt_nxt;
	logic [31:0] offer_addr_nxt;
	hrjs_pb_t pb_st_r, pb_st_nxt;
	hrjs_join_t jn_st_r, jn_st_nxt;
	logic [CNT_W-1:0] pb_cnt_r, pb_cnt_nxt, jn_tmr_r, jn_tmr_nxt;
	logic [BLINK_W-1:0] blink_r, blink_nxt;
	logic short_ev, long_ev, keygen_go, join_go, cancel_go, wr_ctrl;
	logic [31:0] new_mask, rnd_addr;

	// a set command-select line is sampled the same cycle as its byte
	always_comb begin
		rf_tx_valid_nxt = host_rx_valid && cmd_sel_n;
		// no timer on the line, so holding it low past the margin changes nothing
		cmd_valid_nxt = host_rx_valid && !cmd_sel_n;
	end

	// radio data lands in the queue unless it is full or fails the key check while encryption is on; only its release depends on the line
	always_comb begin
		fifo_full = (wp_r[FIFO_AW] != rp_r[FIFO_AW]) && (wp_r[FIFO_AW-1:0] == rp_r[FIFO_AW-1:0]);
		fifo_empty = (wp_r == rp_r);
		release_ok = cmd_sel_n || (defer_r != DEFER_ON && !packet_options_r[PK_RX_PACKET_MODE_BIT]);
		push = rf_rx_valid && !fifo_full && !(enc_en_r && !rf_rx_key_ok);
		pop = !fifo_empty && release_ok && (!uart_out_valid_r || uart_out_ready);
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		uart_out_valid_nxt = pop ? 1'b1 : (uart_out_ready ? 1'b0 : uart_out_valid_r);
		uart_out_data_nxt = pop ? mem[rp_r[FIFO_AW-1:0]] : uart_out_data_r;
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r[FIFO_AW-1:0]] <= rf_rx_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rf_tx_valid_r <= 1'b0;
			rf_tx_data_r <= RESET_BYTE;
			rf_tx_encrypt_r <= 1'b0;
			cmd_valid_r <= 1'b0;
			cmd_data_r <= RESET_BYTE;
			uart_out_valid_r <= 1'b0;
			uart_out_data_r <= RESET_BYTE;
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			rf_tx_valid_r <= rf_tx_valid_nxt;
			rf_tx_data_r <= host_rx_data;
			// only payload is marked for the cipher; the framer adds clear addresses
			rf_tx_encrypt_r <= rf_tx_valid_nxt && enc_en_r;
			cmd_valid_r <= cmd_valid_nxt;
			cmd_data_r <= host_rx_data;
			uart_out_valid_r <= uart_out_valid_nxt;
			uart_out_data_r <= uart_out_data_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// push button, keygen, join and registers
	always_comb begin
		pb_st_nxt = pb_st_r;
		pb_cnt_nxt = pb_cnt_r;
		blink_nxt = '0;
		short_ev = 1'b0;
		long_ev = 1'b0;
		unique case (pb_st_r)
			PB_IDLE: begin
				pb_cnt_nxt = '0;
				if (push_button_line) begin
					pb_st_nxt = PB_HELD;
				end
			end
			PB_HELD: begin
				pb_cnt_nxt = pb_cnt_r + 1'b1;
				if (!push_button_line) begin
					pb_st_nxt = PB_IDLE;
					short_ev = (pb_cnt_r < CNT_W'(SHORT_CYC));
				end else if (pb_cnt_r >= CNT_W'(HOLD_CYC - 1)) begin
					pb_st_nxt = PB_LONG;
				end
			end
			PB_LONG: begin
				blink_nxt = blink_r + 1'b1;
				if (!push_button_line) begin
					pb_st_nxt = PB_IDLE;
					long_ev = 1'b1;
				end
			end
		endcase
		// steady while held, then repeating double blink once the hold is recognised
		led_nxt = (pb_st_nxt == PB_HELD) ||
			(pb_st_nxt == PB_LONG && (blink_r[BLINK_PH_HI:BLINK_PH_LO] == BLINK_ON_A ||
			blink_r[BLINK_PH_HI:BLINK_PH_LO] == BLINK_ON_B));
	end

	always_comb begin
		wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
		lfsr_nxt = {lfsr_r[126:0], lfsr_r[127] ^ lfsr_r[28] ^ lfsr_r[26] ^ lfsr_r[1] ^ rf_noise_bit};
		// keygen always replaces the key, so blocking key change also blocks admin promotion
		keygen_go = (long_ev || (wr_ctrl && reg_wdata[CTL_KEYGEN])) && !security_options_r[SEC_NO_KEY];
		join_go = jn_st_r == JN_IDLE && (short_ev || (wr_ctrl && reg_wdata[CTL_JOIN])) &&
			(is_admin_r ? (key_valid_r && !security_options_r[SEC_NO_SHARE]) : !security_options_r[SEC_NO_KEY]);
		cancel_go = jn_st_r == JN_SEARCH && (short_ev || (wr_ctrl && reg_wdata[CTL_CANCEL]));
		new_mask = (mask_r == MASK_DEFAULT) ? MASK_KEYGEN : mask_r;
		rnd_addr = lfsr_r[95:64] & ~new_mask;
		defer_nxt = defer_r;
		packet_options_nxt = packet_options_r;
		mask_nxt = mask_r;
		own_nxt = own_r;
		target_nxt = target_r;
		scheme_nxt = scheme_r;
		security_options_nxt = security_options_r;
		key_nxt = key_r;
		key_valid_nxt = key_valid_r;
		enc_en_nxt = enc_en_r;
		is_admin_nxt = is_admin_r;
		node_cnt_nxt = node_cnt_r;
		jn_st_nxt = jn_st_r;
		jn_tmr_nxt = '0;
		nv_save_nxt = 1'b0;
		if (reg_wr) begin
			unique case (reg_addr)
				OFS_DEFER: defer_nxt = reg_wdata[7:0];
				OFS_PACKET_OPTIONS: packet_options_nxt = reg_wdata[7:0];
				OFS_MASK: mask_nxt = reg_wdata;
				OFS_OWN: own_nxt = reg_wdata;
				OFS_TARGET: target_nxt = reg_wdata;
				OFS_SCHEME: scheme_nxt = reg_wdata[7:0];
				OFS_SECURITY_OPTIONS: security_options_nxt = reg_wdata[7:0];
				8'h1C: key_nxt[31:0] = reg_wdata;
				8'h20: key_nxt[63:32] = reg_wdata;
				8'h24: key_nxt[95:64] = reg_wdata;
				8'h28: key_nxt[127:96] = reg_wdata;
				default: ;
			endcase
			nv_save_nxt = reg_addr != OFS_CTRL && reg_addr != OFS_STATUS;
		end
		if (wr_ctrl) begin
			if (reg_wdata[CTL_KEY_SET]) begin
				key_valid_nxt = 1'b1;
			end
			if (reg_wdata[CTL_ENC_ON] && key_valid_r) begin
				enc_en_nxt = 1'b1;
			end
			if (reg_wdata[CTL_ENC_OFF]) begin
				enc_en_nxt = 1'b0;
			end
			if (reg_wdata[CTL_KEY_CLR]) begin
				key_nxt = '0;
				key_valid_nxt = 1'b0;
				enc_en_nxt = 1'b0;
				nv_save_nxt = 1'b1;
			end
		end
		if (keygen_go) begin
			key_nxt = lfsr_r ^ {lfsr_r[63:0], lfsr_r[127:64]};
			key_valid_nxt = 1'b1;
			enc_en_nxt = security_options_r[SEC_KEYGEN_ENC];
			is_admin_nxt = 1'b1;
			node_cnt_nxt = '0;
			nv_save_nxt = 1'b1;
			if (mask_r == MASK_DEFAULT) begin
				mask_nxt = MASK_KEYGEN;
				scheme_nxt = security_options_r[SEC_KEYGEN_ENC] ? SCHEME_EXT_ENC : SCHEME_EXT_PLAIN;
			end
			if (!security_options_r[SEC_NO_ADDR]) begin
				own_nxt = rnd_addr;
				target_nxt = rnd_addr | new_mask;
			end
		end
		unique case (jn_st_r)
			JN_IDLE: begin
				if (join_go && !keygen_go) begin
					jn_st_nxt = JN_SEARCH;
				end
			end
			JN_SEARCH: begin
				if (cancel_go || keygen_go || jn_tmr_r >= CNT_W'(JOIN_CYC - 1)) begin
					jn_st_nxt = JN_IDLE;
				end else if (is_admin_r && join_peer_done) begin
					node_cnt_nxt = node_cnt_r + 1'b1;
					jn_st_nxt = JN_IDLE;
				end else if (!is_admin_r && join_rx_valid) begin
					key_nxt = join_rx_key;
					key_valid_nxt = 1'b1;
					enc_en_nxt = 1'b1;
					mask_nxt = join_rx_mask;
					if (!security_options_r[SEC_NO_ADDR]) begin
						own_nxt = join_rx_addr;
					end
					target_nxt = join_admin_addr;
					nv_save_nxt = 1'b1;
					jn_st_nxt = JN_IDLE;
				end else begin
					// counts only while searching, so an exit never leaves an overshoot
					jn_tmr_nxt = jn_tmr_r + 1'b1;
				end
			end
		endcase
		offer_en_nxt = jn_st_nxt == JN_SEARCH;
		offer_addr_nxt = own_r + {16'h0000, node_cnt_nxt} + 32'h00000001;
		// key transfer runs under the factory key, payload under the network key
		cipher_key_nxt = offer_en_nxt ? FACTORY_KEY : key_nxt;
		rdata_nxt = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_DEFER: rdata_nxt = {24'h000000, defer_r};
				OFS_PACKET_OPTIONS: rdata_nxt = {24'h000000, packet_options_r};
				OFS_MASK: rdata_nxt = mask_r;
				OFS_OWN: rdata_nxt = own_r;
				OFS_TARGET: rdata_nxt = target_r;
				OFS_SCHEME: rdata_nxt = {24'h000000, scheme_r};
				OFS_SECURITY_OPTIONS: rdata_nxt = {24'h000000, security_options_r};
				OFS_STATUS: rdata_nxt = {node_cnt_r, 11'h000, !fifo_empty, jn_st_r == JN_SEARCH,
					is_admin_r, enc_en_r, key_valid_r};
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pb_st_r <= PB_IDLE;
			pb_cnt_r <= '0;
			blink_r <= '0;
			status_led_line_r <= 1'b0;
			lfsr_r <= LFSR_SEED;
			defer_r <= RESET_BYTE;
			packet_options_r <= RESET_BYTE;
			mask_r <= MASK_DEFAULT;
			own_r <= ADDR_RESET;
			target_r <= ADDR_RESET;
			scheme_r <= RESET_BYTE;
			security_options_r <= RESET_BYTE;
			key_r <= '0;
			key_valid_r <= 1'b0;
			enc_en_r <= 1'b0;
			is_admin_r <= 1'b0;
			node_cnt_r <= '0;
			jn_st_r <= JN_IDLE;
			jn_tmr_r <= '0;
			nv_save_r <= 1'b0;
			join_search_r <= 1'b0;
			join_as_admin_r <= 1'b0;
			join_offer_addr_r <= '0;
			cipher_key_r <= '0;
			net_key_r <= '0;
			reg_rdata_r <= '0;
		end else begin
			pb_st_r <= pb_st_nxt;
			pb_cnt_r <= pb_cnt_nxt;
			blink_r <= blink_nxt;
			status_led_line_r <= led_nxt;
			lfsr_r <= lfsr_nxt;
			defer_r <= defer_nxt;
			packet_options_r <= packet_options_nxt;
			mask_r <= mask_nxt;
			own_r <= own_nxt;
			target_r <= target_nxt;
			scheme_r <= scheme_nxt;
			security_options_r <= security_options_nxt;
			key_r <= key_nxt;
			key_valid_r <= key_valid_nxt;
			enc_en_r <= enc_en_nxt;
			is_admin_r <= is_admin_nxt;
			node_cnt_r <= node_cnt_nxt;
			jn_st_r <= jn_st_nxt;
			jn_tmr_r <= jn_tmr_nxt;
			nv_save_r <= nv_save_nxt;
			join_search_r <= offer_en_nxt;
			join_as_admin_r <= is_admin_nxt;
			join_offer_addr_r <= offer_addr_nxt;
			cipher_key_r <= cipher_key_nxt;
			net_key_r <= key_nxt;
			reg_rdata_r <= rdata_nxt;
		end
	end

	AST_PAYLOAD_ROUTE: assert property (host_rx_valid && cmd_sel_n |=> rf_tx_valid_r
		&& !cmd_valid_r && rf_tx_data_r == $past(host_rx_data)) else $error("payload not routed");
	AST_CMD_ROUTE: assert property (host_rx_valid && !cmd_sel_n |=> cmd_valid_r
		&& !rf_tx_valid_r) else $error("command byte leaked to radio");
	AST_DEFER_HOLD: assert property (defer_r == DEFER_ON && !cmd_sel_n
		&& !uart_out_valid_r |=> !uart_out_valid_r) else $error("radio data released early");
	AST_KEY_HIDDEN: assert property (reg_rd && reg_addr >= OFS_KEY0
		&& reg_addr <= OFS_KEY3 |=> reg_rdata_r == 32'h00000000) else $error("key read back");
	AST_NO_KEY_NO_ENC: assert property (!key_valid_r |-> !enc_en_r)
		else $error("encryption on without key");
	AST_KEYGEN_DEFAULT: assert property (keygen_go && mask_r == MASK_DEFAULT
		&& !security_options_r[SEC_NO_ADDR] |=> mask_r == MASK_KEYGEN && target_r == (own_r | MASK_KEYGEN)
		&& own_r[7:0] == 8'h00 && is_admin_r) else $error("keygen mask or broadcast wrong");
	AST_KEYGEN_SCHEME: assert property (keygen_go && mask_r == MASK_DEFAULT
		|=> scheme_r == ($past(security_options_r[SEC_KEYGEN_ENC]) ? SCHEME_EXT_ENC : SCHEME_EXT_PLAIN))
		else $error("keygen addressing scheme wrong");
	AST_KEYGEN_KEEP: assert property (keygen_go && mask_r != MASK_DEFAULT && !(reg_wr
		&& (reg_addr == OFS_MASK || reg_addr == OFS_SCHEME)) |=> $stable(mask_r)
		&& $stable(scheme_r)) else $error("preset mask altered");
	AST_RX_REJECT: assert property (rf_rx_valid && enc_en_r && !rf_rx_key_ok
		|=> wp_r == $past(wp_r)) else $error("foreign key traffic accepted");
	AST_NODE_JOIN: assert property (jn_st_r == JN_SEARCH && !is_admin_r
		&& join_rx_valid && !cancel_go && !keygen_go && jn_tmr_r < CNT_W'(JOIN_CYC - 1)
		|=> target_r == $past(join_admin_addr) && key_r == $past(join_rx_key)
		&& jn_st_r == JN_IDLE) else $error("node join not applied");
	AST_JOIN_TIMEOUT: assert property (jn_tmr_r < CNT_W'(JOIN_CYC))
		else $error("join search overran its limit");
endmodule : hrjs_top

/* File: testbench/hrjs_host_model.sv */
`timescale 1ns/1ps
module hrjs_host_model #(
	parameter int TAIL_CYC = 10
) (
	input wire logic clk,
	input wire logic nrst,
	output logic cmd_sel_n,
	output logic host_rx_valid,
	output logic [7:0] host_rx_data,
	input wire logic uart_out_valid_r,
	input wire logic [7:0] uart_out_data_r,
	output logic uart_out_ready
);
	logic slow = 1'b1;
	logic [7:0] got[$];
	initial begin
		cmd_sel_n = 1'b1;
		host_rx_valid = 1'b0;
		host_rx_data = 8'h00;
		uart_out_ready = 1'b0;
	end
	// stalling every other cycle makes the device hold each byte it starts offering right after a ready cycle
	always @(posedge clk) begin
		if (uart_out_valid_r && uart_out_ready)
			got.push_back(uart_out_data_r);
		uart_out_ready <= nrst && !(slow && uart_out_ready);
	end
	task automatic set_sel(input logic v);
		// leaving command mode waits out the margin after the last command byte
		if (v && !cmd_sel_n)
			repeat (TAIL_CYC) @(posedge clk);
		@(posedge clk);
		cmd_sel_n <= v;
	endtask : set_sel
	task automatic send_byte(input logic sel_n, input logic [7:0] v);
		set_sel(sel_n);
		host_rx_valid <= 1'b1;
		host_rx_data <= v;
		@(posedge clk);
		host_rx_valid <= 1'b0;
		host_rx_data <= ~v;
	endtask : send_byte
endmodule : hrjs_host_model

/* File: testbench/test_host_routing_and_join_security.sv */
`timescale 1ns/1ps
module test_host_routing_and_join_security import hrjs_pkg::*;;
	localparam int HOLD = 64;
	localparam int JWAIT = 100;
	localparam logic [127:0] KEY_A = 128'h1F2E3D4C5B6A79880011223344556677;
	localparam logic [127:0] KEY_B = 128'hA0B1C2D3E4F5061728394A5B6C7D8E9F;
	localparam logic [31:0] NODE_BASE = 32'h4A3B2C00;
	logic clk, nrst, cmd_sel_n, host_rx_valid, rf_tx_valid_r, rf_tx_encrypt_r, cmd_valid_r;
	logic rf_rx_valid, rf_rx_key_ok, uart_out_valid_r, uart_out_ready, reg_wr, reg_rd;
	logic push_button_line, status_led_line_r, rf_noise_bit, join_search_r, join_as_admin_r;
	logic join_peer_done, join_rx_valid, nv_save_r;
	logic [7:0] host_rx_data, rf_tx_data_r, cmd_data_r, rf_rx_data, uart_out_data_r, reg_addr;
	logic [31:0] reg_wdata, reg_rdata_r, join_offer_addr_r, join_rx_mask, join_rx_addr;
	logic [31:0] join_admin_addr, d, own;
	logic [127:0] cipher_key_r, net_key_r, join_rx_key;
	logic [3:0] sel_pat = 4'b1001;
	logic [7:0] pat [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5E};
	int n_errors = 0;
	int comparisons = 0;
	hrjs_top #(.HOLD_CYC(HOLD), .SHORT_CYC(16), .JOIN_CYC(JWAIT)) i_hrjs_top (
		.clk, .nrst, .cmd_sel_n, .host_rx_valid, .host_rx_data, .rf_tx_valid_r, .rf_tx_data_r,
		.rf_tx_encrypt_r, .cmd_valid_r, .cmd_data_r, .rf_rx_valid, .rf_rx_data, .rf_rx_key_ok,
		.uart_out_valid_r, .uart_out_data_r, .uart_out_ready, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata_r, .push_button_line, .status_led_line_r, .rf_noise_bit,
		.cipher_key_r, .net_key_r, .join_search_r, .join_as_admin_r, .join_offer_addr_r,
		.join_peer_done, .join_rx_valid, .join_rx_key, .join_rx_mask, .join_rx_addr,
		.join_admin_addr, .nv_save_r
	);
	hrjs_host_model i_hrjs_host_model (
		.clk, .nrst, .cmd_sel_n, .host_rx_valid, .host_rx_data, .uart_out_valid_r,
		.uart_out_data_r, .uart_out_ready
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) rf_noise_bit <= ~rf_noise_bit;
	task automatic ck(input logic [127:0] g, input logic [127:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : ck
	task automatic cv(input logic [31:0] g, input logic [31:0] e);
		ck(128'(g), 128'(e));
	endtask : cv
	task automatic cb(input logic g, input logic e);
		ck(128'(g), 128'(e));
	endtask : cb
	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle
	task automatic rw(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : rw
	task automatic rr(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_r;
	endtask : rr
	task automatic cr(input logic [7:0] a, input logic [31:0] e);
		rr(a);
		cv(d, e);
	endtask : cr
	task automatic rfb(input logic [7:0] v, input logic ok);
		@(posedge clk);
		rf_rx_valid <= 1'b1;
		rf_rx_data <= v;
		rf_rx_key_ok <= ok;
		@(posedge clk);
		rf_rx_valid <= 1'b0;
		rf_rx_data <= ~v;
	endtask : rfb
	task automatic wait_got(input int n);
		repeat (60) if (i_hrjs_host_model.got.size() < n) @(posedge clk);
	endtask : wait_got
	task automatic press(input int n);
		@(posedge clk);
		push_button_line <= 1'b1;
		repeat (2) @(posedge clk);
		cb(status_led_line_r, 1'b1);
		repeat (n - 2) @(posedge clk);
		push_button_line <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : press
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
	endtask : do_reset
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	initial begin
		#(100 * 20000);
		n_errors++;
		end_sim();
	end
	initial begin
		nrst = 1'b0;
		{rf_rx_valid, rf_rx_key_ok, reg_wr, reg_rd, push_button_line, rf_noise_bit} = '0;
		{join_peer_done, join_rx_valid, rf_rx_data, reg_addr, reg_wdata} = '0;
		{join_rx_key, join_rx_mask, join_rx_addr, join_admin_addr} = '0;
		do_reset();
		cr(OFS_MASK, MASK_DEFAULT);
		cr(OFS_TARGET, ADDR_RESET);
		cr(OFS_STATUS, 32'h0);
		cr(8'hFC, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			i_hrjs_host_model.send_byte(sel_pat[i], pat[i]);
			#1;
			cb(rf_tx_valid_r, sel_pat[i]);
			cb(cmd_valid_r, !sel_pat[i]);
			cb(rf_tx_encrypt_r, 1'b0);
			cv(32'(sel_pat[i] ? rf_tx_data_r : cmd_data_r), 32'(pat[i]));
		end
		$display("test routing done");
		i_hrjs_host_model.set_sel(1'b0);
		rfb(8'h5A, 1'b1);
		wait_got(1);
		cv(32'(i_hrjs_host_model.got.size()), 32'h1);
		rw(OFS_PACKET_OPTIONS, 32'h1 << PK_RX_PACKET_MODE_BIT);
		#1;
		cb(nv_save_r, 1'b1);
		rfb(8'h69, 1'b1);
		repeat (20) @(posedge clk);
		cv(32'(i_hrjs_host_model.got.size()), 32'h1);
		rw(OFS_DEFER, 32'(DEFER_ON));
		rw(OFS_PACKET_OPTIONS, 32'h0);
		i_hrjs_host_model.send_byte(1'b0, 8'h77);
		#1;
		cb(cmd_valid_r, 1'b1);
		repeat (20) @(posedge clk);
		cv(32'(i_hrjs_host_model.got.size()), 32'h1);
		cb(uart_out_valid_r, 1'b0);
		rr(OFS_STATUS);
		cb(d[4], 1'b1);
		i_hrjs_host_model.set_sel(1'b1);
		wait_got(2);
		cv(32'(i_hrjs_host_model.got[0]), 32'h5A);
		cv(32'(i_hrjs_host_model.got[1]), 32'h69);
		$display("test receive done");
		for (int i = 0; i < 4; i++) rw(OFS_KEY0 + 8'(4 * i), KEY_A[32 * i +: 32]);
		rw(OFS_CTRL, 32'h1 << CTL_KEY_SET);
		settle();
		ck(net_key_r, KEY_A);
		cr(OFS_KEY0, 32'h0);
		rw(OFS_CTRL, 32'h1 << CTL_ENC_ON);
		cr(OFS_STATUS, 32'h3);
		i_hrjs_host_model.slow = 1'b0;
		i_hrjs_host_model.send_byte(1'b1, 8'h11);
		#1;
		cb(rf_tx_encrypt_r, 1'b1);
		rfb(8'h22, 1'b0);
		rfb(8'h33, 1'b1);
		wait_got(3);
		repeat (10) @(posedge clk);
		cv(32'(i_hrjs_host_model.got.size()), 32'h3);
		cv(32'(i_hrjs_host_model.got[2]), 32'h33);
		rw(OFS_CTRL, 32'h1 << CTL_ENC_OFF);
		cr(OFS_STATUS, 32'h1);
		rw(OFS_CTRL, 32'h1 << CTL_KEY_CLR);
		rr(OFS_STATUS);
		cb(d[0], 1'b0);
		$display("test key done");
		rw(OFS_CTRL, 32'h1 << CTL_KEYGEN);
		settle();
		cr(OFS_MASK, MASK_KEYGEN);
		cr(OFS_SCHEME, 32'(SCHEME_EXT_PLAIN));
		rr(OFS_OWN);
		own = d;
		cv(32'(own[7:0]), 32'h0);
		cr(OFS_TARGET, own | MASK_KEYGEN);
		rr(OFS_STATUS);
		cb(d[0] & d[2], 1'b1);
		cb(|net_key_r, 1'b1);
		rw(OFS_CTRL, 32'h1 << CTL_JOIN);
		settle();
		cb(join_search_r & join_as_admin_r, 1'b1);
		cv(join_offer_addr_r, own + 32'h1);
		ck(cipher_key_r, FACTORY_KEY);
		join_peer_done <= 1'b1;
		@(posedge clk);
		join_peer_done <= 1'b0;
		settle();
		cb(join_search_r, 1'b0);
		cv(join_offer_addr_r, own + 32'h2);
		rw(OFS_CTRL, 32'h1 << CTL_JOIN);
		repeat (JWAIT - 10) @(posedge clk);
		cb(join_search_r, 1'b1);
		repeat (20) @(posedge clk);
		cb(join_search_r, 1'b0);
		press(3);
		cb(join_search_r, 1'b1);
		press(3);
		cb(join_search_r, 1'b0);
		$display("test admin join done");
		do_reset();
		rw(OFS_SECURITY_OPTIONS, 32'h1 << SEC_KEYGEN_ENC);
		press(HOLD + 20);
		cr(OFS_MASK, MASK_KEYGEN);
		cr(OFS_SCHEME, 32'(SCHEME_EXT_ENC));
		rw(OFS_MASK, 32'h0000FFFF);
		rw(OFS_SCHEME, 32'h5);
		rw(OFS_CTRL, 32'h1 << CTL_KEYGEN);
		settle();
		cr(OFS_MASK, 32'h0000FFFF);
		cr(OFS_SCHEME, 32'h5);
		rr(OFS_OWN);
		own = d;
		cr(OFS_TARGET, own | 32'h0000FFFF);
		rw(OFS_CTRL, 32'h1 << CTL_JOIN);
		settle();
		cv(join_offer_addr_r, own + 32'h1);
		rw(OFS_CTRL, 32'h1 << CTL_CANCEL);
		settle();
		cb(join_search_r, 1'b0);
		$display("test preset mask done");
		do_reset();
		press(3);
		cb(join_as_admin_r, 1'b0);
		ck(cipher_key_r, FACTORY_KEY);
		join_rx_valid <= 1'b1;
		{join_rx_key, join_rx_mask} <= {KEY_B, MASK_KEYGEN};
		{join_rx_addr, join_admin_addr} <= {NODE_BASE + 32'h1, NODE_BASE};
		@(posedge clk);
		join_rx_valid <= 1'b0;
		{join_rx_key, join_rx_mask, join_rx_addr} <= ~{join_rx_key, join_rx_mask, join_rx_addr};
		settle();
		cb(join_search_r, 1'b0);
		ck(cipher_key_r, KEY_B);
		cr(OFS_TARGET, NODE_BASE);
		cr(OFS_OWN, NODE_BASE + 32'h1);
		rw(OFS_SECURITY_OPTIONS, 32'h1 << SEC_NO_KEY);
		rw(OFS_CTRL, 32'h1 << CTL_KEYGEN);
		settle();
		rr(OFS_STATUS);
		cb(d[2], 1'b0);
		$display("test node join done");
		end_sim();
	end
endmodule : test_host_routing_and_join_security
